// ### design/uplink_framer_pkg.sv
// Package for the uplink burst framer: field layouts, patterns, limits and types.
// Assumes a single clock domain; no bus, all configuration arrives on plain ports.
package uplink_framer_pkg;

   // ----------------------------------------------------------------
   // Burst layout
   // ----------------------------------------------------------------
   localparam int BURST_BITS = 36;
   localparam int FIELD_BITS = 12;
   localparam logic [11:0] CORE_PILOT = 12'h42E;
   localparam logic [11:0] EXT_PILOT = 12'h5F2;
   localparam logic [11:0] SYNC_PREAMBLE = 12'hCCC;
   localparam logic [7:0] SYNC_PILOT = 8'hCB;
   localparam int CORE_BURSTS = 24;
   localparam int CORE_PAYLOAD_BITS = 186;
   localparam int SYNC_RSV_POS = 20;
   localparam int SYNC_PAT_LSB = 21;
   localparam int SYNC_ADDR_LSB = 24;
   localparam int SYNC_GRP_LSB = 32;
   localparam int SYNC_CRC_LSB = 34;

   // ----------------------------------------------------------------
   // Payload and link layer
   // ----------------------------------------------------------------
   localparam logic [7:0] MIN_SERVICE_BYTES = 8'h14;
   localparam logic [7:0] MAX_SIZE_IND = 8'hF5;
   localparam logic [7:0] MAX_CUSTOM_BYTES = 8'hFE;
   localparam logic [7:0] SEL_METERING = 8'h00;
   localparam logic [7:0] SEL_USER_LO = 8'h30;
   localparam logic [7:0] SEL_USER_HI = 8'h3F;
   localparam logic [1:0] MODE_FIXED = 2'h0;
   localparam logic [1:0] MODE_VARIABLE = 2'h1;
   localparam logic [7:0] METER_MIN_BYTES = 8'h13;
   localparam logic [7:0] METER_MAX_BYTES = 8'hFF;
   localparam int MAX_BYTES = 256;
   localparam int BYTE_BITS = 8;
   localparam logic [11:0] HDR_CRC_END = 12'h008;
   localparam logic [11:0] PAY_CRC_END = 12'h010;
   localparam logic [11:0] PHY_HDR_BITS = 12'h018;
   localparam logic [11:0] MODE_BITS = 12'h002;

   typedef enum logic [1:0] {
      pattern_group_one = 2'h0,
      pattern_group_two = 2'h1,
      pattern_group_three = 2'h2
   } pattern_group_t;

   typedef struct packed {
      logic variable_mode;
      logic [7:0] link_layer_selector;
      logic sync_enable;
      logic [2:0] pattern_number;
      pattern_group_t pattern_group;
      logic [7:0] short_address;
   } frame_cfg_t;

   typedef struct packed {
      logic [7:0] header_crc;
      logic [7:0] payload_crc;
   } frame_crc_t;

   typedef struct packed {
      logic valid;
      logic sync;
      logic ext;
      logic last;
      logic [BURST_BITS-1:0] bits;
   } burst_out_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOAD = 3'h1,
      ST_PAD = 3'h3,
      ST_SYNC = 3'h2,
      ST_BURST = 3'h6
   } framer_state_t;

endpackage

// ### design/uplink_sync_crc.sv
// Two-bit check over the sync information field of the sync burst.
// Assumes the polynomial is supplied as a parameter; combinational only.
`timescale 1ns/10ps
`default_nettype none
module uplink_sync_crc #(
   parameter logic [1:0] POLY = 2'h3
) (
   input wire logic [13:0] info,
   output logic [1:0] crc
);
   always_comb begin
      logic [1:0] r;
      logic fb;
      r = 2'h0;
      fb = 1'b0;
      for (int i = 0; i < 14; i++) begin
         fb = info[i] ^ r[1];
         r = {r[0], 1'b0} ^ (fb ? POLY : 2'h0);
      end
      crc = r;
   end
endmodule
`default_nettype wire

// ### design/uplink_burst_framer.sv
// Uplink burst framer: collects a link-layer unit, builds the payload and emits 36-bit bursts.
// Assumes header and payload checks come from an outside engine over unpadded bytes.
//
// Contract
// - Variable mode prefixes selector to 1..254 bytes; capture stops at 244 bytes after the selector.
// - Selector is 0x00 or 0x30-0x3F only.
// - Metering payload follows the fixed field layout.
// - Metering address eight bytes, most significant first.
// - Burst: data 0-11, pilot 12-23, data 24-35.
// - Core bursts carry the core pilot pattern.
// - Extension bursts carry the extension pilot pattern.
// - Optional sync burst has the fixed field layout.
// - Sync preamble and sync pilot are fixed patterns.
// - Sync reserved bit is zero.
// - Sync carries pattern number and address low byte.
// - Pattern group coded 00, 01, 10.
// - Two-bit sync check over bits 20-33.
// - Extension only when payload exceeds 186 bits.
// - Core frame is exactly 24 bursts.
// - Extension adds one burst per extra byte.
// - Payload: two checks, size, data, mode.
// - Checks and size form the header.
// - Size holds unpadded length, 1 to 245.
// - Pad with zeros to twenty data bytes.
// - Padding excluded from check calculation.
// - Mode field 00 fixed, 01 variable.
// - Metering frames carry the control-info byte.
`timescale 1ns/10ps
`default_nettype none
module uplink_burst_framer (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire uplink_framer_pkg::frame_cfg_t cfg,
   input wire logic start,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_last,
   output logic in_ready,
   output logic crc_req,
   output logic [7:0] crc_byte,
   output logic crc_byte_valid,
   input wire uplink_framer_pkg::frame_crc_t crc_in,
   input wire logic crc_done,
   input wire logic out_ready,
   output uplink_framer_pkg::burst_out_t burst,
   output logic busy,
   output logic cfg_error
);
   import uplink_framer_pkg::*;

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [7:0] mem [MAX_BYTES];
   framer_state_t state;
   logic [8:0] wr_count;
   logic [8:0] unit_len;
   frame_cfg_t cfg_hold;
   frame_crc_t crc_hold;
   logic crc_wait;
   logic [11:0] bit_pos;
   logic [11:0] total_bits;
   logic [8:0] burst_count;
   logic [8:0] total_bursts;
   logic [1:0] sync_crc;
   logic [BURST_BITS-1:0] sync_word;
   logic take_start;
   logic load_done;
   logic take_burst;

   function automatic logic selector_ok(input logic [7:0] sel);
      selector_ok = (sel == SEL_METERING) || (sel >= SEL_USER_LO && sel <= SEL_USER_HI);
   endfunction

   // A reserved selector in variable mode refuses the whole frame.
   function automatic logic start_refused(input frame_cfg_t c);
      start_refused = c.variable_mode && !selector_ok(c.link_layer_selector);
   endfunction

   // Service-data bits after zero padding to the core-frame minimum.
   function automatic logic [11:0] service_bits(input logic [8:0] len);
      logic [11:0] n;
      n = 12'(len);
      if (n < 12'(MIN_SERVICE_BYTES)) begin
         n = 12'(MIN_SERVICE_BYTES);
      end
      service_bits = n * 12'(BYTE_BITS);
   endfunction

   // Pilot pattern of a data burst, core or extension.
   function automatic logic [11:0] pilot_for(input logic ext);
      pilot_for = ext ? EXT_PILOT : CORE_PILOT;
   endfunction

   // Payload bit i, counted from bit 7 of the header check.
   function automatic logic payload_bit(input logic [11:0] i);
      logic [8:0] byte_idx;
      logic [11:0] svc_bits;
      logic [11:0] k;
      byte_idx = 9'h0;
      k = 12'h0;
      svc_bits = service_bits(unit_len);
      if (i < HDR_CRC_END) begin
         payload_bit = crc_hold.header_crc[3'(HDR_CRC_END - 12'h1 - i)];
      end else if (i < PAY_CRC_END) begin
         payload_bit = crc_hold.payload_crc[3'(PAY_CRC_END - 12'h1 - i)];
      end else if (i < PHY_HDR_BITS) begin
         payload_bit = unit_len[3'(PHY_HDR_BITS - 12'h1 - i)];
      end else if (i < PHY_HDR_BITS + svc_bits) begin
         k = i - PHY_HDR_BITS;
         byte_idx = k[11:3];
         // Zero padding lies past the stored unit.
         payload_bit = (byte_idx < unit_len) ? mem[byte_idx[7:0]][3'(3'h7 - k[2:0])] : 1'b0;
      end else begin
         k = i - PHY_HDR_BITS - svc_bits;
         payload_bit = cfg_hold.variable_mode ? MODE_VARIABLE[1 - k[0]] : MODE_FIXED[1 - k[0]];
      end
   endfunction

   // Twelve payload bits from base upward; bits past the end read as zero.
   function automatic logic [11:0] data_field(input logic [11:0] base);
      logic [11:0] f;
      f = 12'h0;
      for (int j = 0; j < FIELD_BITS; j++) begin
         f[j] = (base + 12'(j) < total_bits) ? payload_bit(base + 12'(j)) : 1'b0;
      end
      data_field = f;
   endfunction

   // ----------------------------------------------------------------
   // Sync burst
   // ----------------------------------------------------------------
   uplink_sync_crc u_sync_crc (
      .info(sync_word[SYNC_CRC_LSB-1:SYNC_RSV_POS]),
      .crc(sync_crc)
   );

   // Sync fields come from the configuration held at start.
   always_comb begin
      sync_word = '0;
      sync_word[FIELD_BITS-1:0] = SYNC_PREAMBLE;
      sync_word[SYNC_RSV_POS-1:FIELD_BITS] = SYNC_PILOT;
      sync_word[SYNC_RSV_POS] = 1'b0;
      sync_word[SYNC_ADDR_LSB-1:SYNC_PAT_LSB] = cfg_hold.pattern_number;
      sync_word[SYNC_GRP_LSB-1:SYNC_ADDR_LSB] = cfg_hold.short_address;
      sync_word[SYNC_CRC_LSB-1:SYNC_GRP_LSB] = cfg_hold.pattern_group;
      sync_word[BURST_BITS-1:SYNC_CRC_LSB] = 2'h0;
   end

   // ----------------------------------------------------------------
   // Handshake qualifiers
   // ----------------------------------------------------------------
   // A refused start leaves every capture path untouched except cfg_hold, which still loads cfg.
   always_comb begin
      take_start = (state == ST_IDLE) && start && !start_refused(cfg);
      // Loading also ends at the size-field limit, so a long unit cannot hang the frame.
      load_done = (state == ST_LOAD) && in_valid && in_ready
         && (in_last || wr_count + 9'h1 >= 9'(MAX_SIZE_IND));
      // A burst leaves when it is shown and the consumer is ready.
      take_burst = burst.valid && out_ready;
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         cfg_hold <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  cfg_hold <= cfg;
               end
               if (take_start) begin
                  state <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (load_done) begin
                  state <= ST_PAD;
               end
            end
            ST_PAD: begin
               // The check answer must follow the last unit byte; an earlier pulse is missed.
               if (crc_done || !crc_wait) begin
                  state <= cfg_hold.sync_enable ? ST_SYNC : ST_BURST;
               end
            end
            ST_SYNC: begin
               if (take_burst) begin
                  state <= ST_BURST;
               end
            end
            ST_BURST: begin
               if (take_burst && burst.last) begin
                  state <= ST_IDLE;
               end
            end
            // An unused code falls back to idle.
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Refusal and status
   // ----------------------------------------------------------------
   // Set by a refused start, cleared by the next start that is taken.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg_error <= 1'b0;
      end else if (state == ST_IDLE && start) begin
         cfg_error <= start_refused(cfg);
      end
   end

   // A refused start never shows as busy.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
      end else begin
         busy <= (state != ST_IDLE) || take_start;
      end
   end

   // ----------------------------------------------------------------
   // Unit capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      // In variable mode byte 0 holds the selector and the unit starts at byte 1.
      if (take_start) begin
         mem[0] <= cfg.link_layer_selector;
      end else if (state == ST_LOAD && in_valid && in_ready) begin
         mem[wr_count[7:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_count <= 9'h0;
         unit_len <= 9'h0;
         in_ready <= 1'b0;
      end else begin
         if (take_start) begin
            wr_count <= cfg.variable_mode ? 9'h1 : 9'h0;
            in_ready <= 1'b1;
         end else if (state == ST_LOAD && in_valid && in_ready) begin
            wr_count <= wr_count + 9'h1;
            // Capacity bound: size field tops out at 245 bytes.
            if (in_last || wr_count + 9'h1 >= 9'(MAX_SIZE_IND)) begin
               in_ready <= 1'b0;
               unit_len <= wr_count + 9'h1;
            end
         end
      end
   end

   // Unpadded bytes stream out to the check engine alongside capture.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         crc_req <= 1'b0;
         crc_byte <= 8'h0;
         crc_byte_valid <= 1'b0;
         crc_wait <= 1'b0;
      end else begin
         crc_byte_valid <= 1'b0;
         crc_req <= 1'b0;
         // The selector leads the checked bytes only in variable mode.
         if (take_start) begin
            crc_req <= 1'b1;
            crc_wait <= 1'b1;
            crc_byte <= cfg.link_layer_selector;
            crc_byte_valid <= cfg.variable_mode;
         end else if (state == ST_LOAD && in_valid && in_ready) begin
            crc_byte <= in_data;
            crc_byte_valid <= 1'b1;
         end else if (state == ST_PAD && crc_done) begin
            crc_wait <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         crc_hold <= '0;
      end else if (state == ST_PAD && crc_done) begin
         crc_hold <= crc_in;
      end
   end

   // ----------------------------------------------------------------
   // Burst emission
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bit_pos <= 12'h0;
         burst_count <= 9'h0;
         total_bits <= 12'h0;
         total_bursts <= 9'h0;
         burst <= '0;
      end else begin
         if (state == ST_PAD && (crc_done || !crc_wait)) begin
            // Header 24 bits, data padded to 20 bytes, mode 2 bits.
            total_bits <= PHY_HDR_BITS + MODE_BITS + service_bits(unit_len);
            // Extension grows one burst per byte beyond the core capacity.
            total_bursts <= (unit_len <= 9'(MIN_SERVICE_BYTES)) ? 9'(CORE_BURSTS) :
               9'(CORE_BURSTS) + unit_len - 9'(MIN_SERVICE_BYTES);
            bit_pos <= 12'h0;
            burst_count <= 9'h0;
            burst <= '0;
         end else if (take_burst) begin
            burst.valid <= 1'b0;
            // A sync burst does not advance the payload position.
            if (!burst.sync) begin
               bit_pos <= bit_pos + 12'(2 * FIELD_BITS);
               burst_count <= burst_count + 9'h1;
            end
         end else if (!burst.valid && state == ST_SYNC) begin
            burst.valid <= 1'b1;
            burst.sync <= 1'b1;
            burst.ext <= 1'b0;
            burst.last <= 1'b0;
            burst.bits <= {sync_crc, sync_word[SYNC_CRC_LSB-1:0]};
         end else if (!burst.valid && state == ST_BURST) begin
            burst.valid <= 1'b1;
            burst.sync <= 1'b0;
            burst.ext <= burst_count >= 9'(CORE_BURSTS);
            // The last flag marks the final burst of core and extension together.
            burst.last <= burst_count + 9'h1 == total_bursts;
            burst.bits[FIELD_BITS-1:0] <= data_field(bit_pos);
            burst.bits[2*FIELD_BITS-1:FIELD_BITS] <= pilot_for(burst_count >= 9'(CORE_BURSTS));
            burst.bits[BURST_BITS-1:2*FIELD_BITS] <= data_field(bit_pos + 12'(FIELD_BITS));
         end
      end
   end

endmodule
`default_nettype wire

// ### testbench/uplink_framer_properties.sv
// Checker for the uplink burst framer, seeing only its top-level ports.
// Assumes cfg is held steady for the whole of a frame.
`timescale 1ns/10ps
`default_nettype none
module uplink_framer_properties (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire uplink_framer_pkg::frame_cfg_t cfg,
   input wire logic start,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_ready,
   input wire logic crc_req,
   input wire logic [7:0] crc_byte,
   input wire logic crc_byte_valid,
   input wire logic out_ready,
   input wire uplink_framer_pkg::burst_out_t burst,
   input wire logic busy,
   input wire logic cfg_error
);
   import uplink_framer_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic bad_sel;
   assign bad_sel = cfg.variable_mode && cfg.link_layer_selector != SEL_METERING
      && (cfg.link_layer_selector < SEL_USER_LO || cfg.link_layer_selector > SEL_USER_HI);
   sequence s_go;
      start && !busy;
   endsequence
   sequence s_sync_take;
      burst.valid && burst.sync && out_ready;
   endsequence
   sequence s_core_next;
      !burst.valid ##1 (burst.valid && !burst.sync && !burst.ext);
   endsequence
   a_core_pilot: assert property (burst.valid && !burst.sync && !burst.ext |-> burst.bits[23:12] == CORE_PILOT)
      else $error("core pilot wrong");
   a_ext_pilot: assert property (burst.valid && burst.ext && !burst.sync |-> burst.bits[23:12] == EXT_PILOT)
      else $error("extension pilot wrong");
   a_sync_fixed: assert property (burst.valid && burst.sync |-> burst.bits[19:0] == {SYNC_PILOT, SYNC_PREAMBLE})
      else $error("sync preamble or pilot wrong");
   a_sync_rsv: assert property (burst.valid && burst.sync |-> !burst.bits[SYNC_RSV_POS])
      else $error("sync reserved bit set");
   a_sync_cfg: assert property (burst.valid && burst.sync |-> burst.bits[31:21] == {cfg.short_address, cfg.pattern_number})
      else $error("sync pattern or address wrong");
   a_sync_group: assert property (burst.valid && burst.sync |-> burst.bits[33:32] == cfg.pattern_group)
      else $error("sync group wrong");
   a_sync_first: assert property (s_sync_take |=> s_core_next)
      else $error("core burst does not follow sync");
   a_start_take: assert property (s_go and !bad_sel |=> crc_req && in_ready)
      else $error("start not taken");
   a_sel_refuse: assert property (s_go and bad_sel |=> cfg_error && !busy && !in_ready)
      else $error("reserved selector not refused");
   a_crc_echo: assert property (!cfg.variable_mode && in_valid && in_ready |=> crc_byte_valid && crc_byte == $past(in_data))
      else $error("unit byte not passed to check engine");
endmodule
bind uplink_burst_framer uplink_framer_properties chk (.clk_sys, .rstn, .cfg, .start, .in_valid, .in_data,
   .in_ready, .crc_req, .crc_byte, .crc_byte_valid, .out_ready, .burst, .busy, .cfg_error);
`default_nettype wire

// ### testbench/uplink_far_side_model.sv
// Far side of the framer: the outside check engine and the burst consumer.
// Assumes the check answer is wanted three cycles after the last unit byte.
`timescale 1ns/10ps
`default_nettype none
module uplink_far_side_model #(
   parameter logic [15:0] CRC_VAL = 16'h5AC3
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic stall,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic in_last,
   output logic out_ready,
   output uplink_framer_pkg::frame_crc_t crc_in,
   output logic crc_done
);
   import uplink_framer_pkg::*;
   logic [1:0] wait_cnt;
   logic [1:0] beat;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wait_cnt <= 2'h0;
         crc_done <= 1'b0;
         crc_in <= ~CRC_VAL;
      end else begin
         if (in_valid && in_ready && in_last)
            wait_cnt <= 2'h3;
         else if (wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
         crc_done <= wait_cnt == 2'h1;
         crc_in <= (wait_cnt == 2'h1) ? CRC_VAL : ~CRC_VAL;
      end
   end
   // A slow consumer takes one burst in four cycles.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         beat <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         beat <= beat + 2'h1;
         out_ready <= !stall || beat == 2'h2;
      end
   end
endmodule
`default_nettype wire

// ### testbench/uplink_burst_framer_tb.sv
// Self-checking bench for the uplink burst framer.
// Assumes the far-side model answers checks and consumes bursts.
`timescale 1ns/10ps
`default_nettype none
module uplink_burst_framer_tb;
   import uplink_framer_pkg::*;
   localparam logic [15:0] CRC_VAL = 16'h5AC3;
   localparam logic [1:0] SYNC_POLY = 2'h3;
   logic clk_sys, rstn, start, in_valid, in_last, in_ready, crc_req, crc_byte_valid;
   logic crc_done, out_ready, busy, cfg_error, stall;
   logic [7:0] in_data, crc_byte;
   frame_cfg_t cfg;
   frame_crc_t crc_in;
   burst_out_t burst;
   int num_errors, n_tests;
   uplink_burst_framer uut (.clk_sys, .rstn, .cfg, .start, .in_valid, .in_data, .in_last, .in_ready,
      .crc_req, .crc_byte, .crc_byte_valid, .crc_in, .crc_done, .out_ready, .burst, .busy, .cfg_error);
   uplink_far_side_model #(.CRC_VAL(CRC_VAL)) far (.clk_sys, .rstn, .stall, .in_valid, .in_ready,
      .in_last, .out_ready, .crc_in, .crc_done);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   function automatic logic [7:0] ubyte(input int j);
      return 8'(j * 7 + 1);
   endfunction
   function automatic logic [1:0] sync_chk(input logic [13:0] info);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 0; i < 14; i++)
         r = {r[0], 1'b0} ^ ((info[i] ^ r[1]) ? SYNC_POLY : 2'h0);
      return r;
   endfunction
   task automatic check(input string what, input logic [38:0] exp, input logic [38:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run_frame(input logic vm, input logic [7:0] sel, input int len, input logic syn,
         input logic [1:0] grp, input logic stl, input logic bad);
      logic p [0:1023];
      logic [7:0] bv;
      logic [38:0] e;
      int size, svc, nb, k, c, w;
      foreach (p[i]) p[i] = 1'b0;
      size = len + int'(vm);
      svc = (size < 20) ? 20 : size;
      nb = svc + 4;
      for (int i = 0; i < svc + 3; i++) begin
         if (i < 2) bv = i ? CRC_VAL[7:0] : CRC_VAL[15:8];
         else if (i == 2) bv = 8'(size);
         else if (i - 3 >= size) bv = 8'h00;
         else if (vm && i == 3) bv = sel;
         else bv = ubyte(i - 3 - int'(vm));
         for (int b = 0; b < 8; b++) p[i * 8 + b] = bv[7 - b];
      end
      p[(svc + 3) * 8 + 1] = vm;
      repeat (4) @(posedge clk_sys);
      cfg <= '{vm, sel, syn, 3'h5, pattern_group_t'(grp), 8'hA5};
      stall <= stl;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      if (bad) begin
         repeat (2) @(posedge clk_sys);
         #1;
         check("refusal", 39'h4, {36'h0, cfg_error, busy, in_ready});
         return;
      end
      for (int i = 0; i < len; i++) begin
         in_valid <= 1'b1;
         in_data <= ubyte(i);
         in_last <= i == len - 1;
         w = 0;
         do @(posedge clk_sys); while (in_ready !== 1'b1 && ++w < 100);
      end
      in_valid <= 1'b0;
      in_data <= 8'hFF;
      k = 0;
      w = 0;
      while (k < nb + int'(syn) && w < 3000) begin
         @(posedge clk_sys);
         #1;
         w++;
         if (burst.valid === 1'b1 && out_ready === 1'b1) begin
            c = k - int'(syn);
            e = {3'b000, grp, 8'hA5, 3'h5, 1'b0, SYNC_PILOT, SYNC_PREAMBLE};
            if (c < 0) begin
               e[35:34] = sync_chk(e[33:20]);
               check("sync burst", {3'b100, e[35:0]}, {burst.sync, burst.ext, burst.last, burst.bits});
            end else begin
               for (int j = 0; j < 12; j++) begin
                  e[j] = p[c * 24 + j];
                  e[24 + j] = p[c * 24 + 12 + j];
               end
               e[23:12] = (c < CORE_BURSTS) ? CORE_PILOT : EXT_PILOT;
               e[38:36] = {1'b0, c >= CORE_BURSTS, c == nb - 1};
               check("burst", e, {burst.sync, burst.ext, burst.last, burst.bits});
            end
            k++;
         end
      end
      check("burst count", 39'(nb + int'(syn)), 39'(k));
   endtask
   initial begin
      rstn = 1'b0;
      start = 1'b0;
      in_valid = 1'b0;
      in_data = 8'h00;
      in_last = 1'b0;
      cfg = '0;
      stall = 1'b0;
      num_errors = 0;
      n_tests = 0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      run_frame(1'b0, 8'h00, 5, 1'b1, 2'h1, 1'b0, 1'b0);
      run_frame(1'b1, 8'h00, 25, 1'b0, 2'h0, 1'b1, 1'b0);
      run_frame(1'b1, 8'h3F, 19, 1'b1, 2'h2, 1'b0, 1'b0);
      run_frame(1'b1, 8'h2F, 4, 1'b0, 2'h0, 1'b0, 1'b1);
      finish_test();
   end
   initial begin
      #400000;
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
